// file: src/cei_pkg.sv
// constants, types and carriers of the exception and interrupt entry block
package cei_pkg;

  // ****************************************
  // register indices (avalon word addresses)
  // ****************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_SAVED_PC = 4'h1;
  localparam logic [3:0] REG_SAVED_STATUS = 4'h2;
  localparam logic [3:0] REG_EXC_CODE = 4'h3;
  localparam logic [3:0] REG_INT_CODE = 4'h4;
  localparam logic [3:0] REG_VECTOR_BASE = 4'h5;
  localparam logic [3:0] REG_DEBUG_BASE = 4'h6;
  localparam logic [3:0] REG_BREAK_CONTROL = 4'h7;
  localparam logic [3:0] REG_NMI_CONTROL = 4'h8;

  // ****************************************
  // status word fields and reset values
  // ****************************************
  localparam int SW_PRIV_BIT = 30;
  localparam int SW_BANK_BIT = 29;
  localparam int SW_BLOCK_BIT = 28;
  localparam int SW_FPD_BIT = 15;
  localparam int SW_IMASK_LO = 4;
  localparam logic [31:0] SW_RESET = 32'h700000f0;
  localparam logic [31:0] SW_WRITE_MASK = 32'h700083f3;
  localparam int BRK_DEBUG_EN_BIT = 0;
  localparam int NMI_ACCEPT_BIT = 0;
  localparam logic [31:0] BASE_RESET = 32'h00000000;

  // ****************************************
  // opcodes, event codes and vectors
  // ****************************************
  localparam logic [15:0] OP_UNDEF = 16'hfffd;
  localparam logic [11:0] EVT_GEN_ILL = 12'h180;
  localparam logic [11:0] EVT_SLOT_ILL = 12'h1a0;
  localparam logic [11:0] EVT_FPU_DIS = 12'h800;
  localparam logic [11:0] EVT_SLOT_FPU = 12'h820;
  localparam logic [11:0] EVT_UBREAK = 12'h1e0;
  localparam logic [11:0] EVT_FPU_EXC = 12'h120;
  localparam logic [11:0] EVT_NMI = 12'h1c0;
  localparam logic [11:0] EVT_LVL_BASE = 12'h200;
  localparam logic [11:0] EVT_LVL_STEP = 12'h020;
  localparam logic [11:0] EVT_BL_RESET = 12'h020;
  localparam logic [11:0] EVT_NONE = 12'h000;
  localparam logic [31:0] VEC_GENERAL = 32'h00000100;
  localparam logic [31:0] VEC_INTERRUPT = 32'h00000600;
  localparam logic [31:0] RESET_ADDR = 32'ha0000000;
  localparam logic [31:0] INSN_BYTES = 32'h00000002;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CEI_NONE = 3'b000,
    CEI_GEN_ILL = 3'b001,
    CEI_SLOT_ILL = 3'b010,
    CEI_FPU_DIS = 3'b011,
    CEI_SLOT_FPU = 3'b100,
    CEI_FPU_EXC = 3'b101,
    CEI_UBREAK = 3'b110,
    CEI_INTR = 3'b111
  } cei_kind_e;

  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic in_slot;
    logic [31:0] pc;
    logic priv;
    logic gbr_access;
    logic pc_modify;
    logic pc_relative;
  } cei_dec_s;

  typedef struct packed {
    logic redirect;
    logic cpu_reset;
    logic [31:0] target;
  } cei_entry_s;

endpackage

// file: src/cei_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module cei_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: src/cei_entry.sv
// exception and interrupt entry unit with avalon register port
// Contract
// RULE1: undefined code fffd outside slot writes 180 and vectors to base plus 100.
// RULE2: privileged instructions in user mode are illegal, except global base forms.
// RULE3: undefined or privileged instruction in delay slot gives slot code 1a0.
// RULE4: pc-modifying, pc-relative move or move-address in delay slot is slot illegal.
// RULE5: slot exceptions save slot address minus 2 and current status word.
// RULE6: general illegal, fp disable and fp exceptions save faulting address.
// RULE7: every entry sets block, privilege and bank bits to one.
// RULE8: fp instruction outside slot with fp disabled writes 800, vector 100.
// RULE9: fp instructions are top nibble f except fffd, plus fp comm/status moves.
// RULE10: fp instruction in slot with fp disabled writes 820.
// RULE11: user break writes 1e0; saves break address, or next one after execution.
// RULE12: user break goes to debug base if enabled, else vector base plus 100.
// RULE13: fp operation exception writes 120, vector base plus 100.
// RULE14: nmi edge writes 1c0 to interrupt code, vector base plus 600.
// RULE15: nmi ignores mask when block is 0; software picks when block is 1.
// RULE16: level interrupt taken at boundary when level beats mask and block is 0.
// RULE17: interrupt entry saves following instruction address and current status.
// RULE18: accepted level is never copied into the status mask.
// RULE19: level and peripheral interrupts are masked while block bit is 1.
// RULE20: peripheral interrupt writes its own code, vector base plus 600.
// RULE21: software sets peripheral levels within 0 to 15.
// RULE22: non-break exception with block set resets cpu, code 20, jumps a0000000.
// RULE23: ordinary interrupt waits while blocked, except in sleep or standby.
// RULE24: level codes step by 20 from level 15 down to level 1.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module cei_entry (
  input wire logic clk_sys,
  input wire logic srst,
  input cei_pkg::cei_dec_s dec,
  input wire logic fpu_exc,
  input wire logic [31:0] fpu_pc,
  input wire logic ubreak,
  input wire logic ubreak_post,
  input wire logic [31:0] ubreak_pc,
  input wire logic int_boundary,
  input wire logic [31:0] int_next_pc,
  input wire logic sleeping,
  input wire logic nmi_pin,
  input wire logic [3:0] external_level_inputs,
  input wire logic periph_req,
  input wire logic [3:0] periph_level,
  input wire logic [11:0] periph_code,
  output logic periph_ack_q,
  output cei_pkg::cei_entry_s entry_q,
  output logic [31:0] status_word_q,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ****************************************
  // state
  // ****************************************
  logic [31:0] saved_pc_q, saved_status_q, vector_base_q, debug_base_q;
  logic [11:0] exc_code_q, int_code_q;
  logic brk_debug_en_q, nmi_accept_q, nmi_prev_q, nmi_pend_q;
  logic nmi_s;
  logic [3:0] lvl_s;
  logic bus_req, bus_wr;

  // ****************************************
  // decode helpers
  // ****************************************
  // fp class: top nibble f except fffd, or fp comm/status load/store
  function automatic logic is_fp_insn(input logic [15:0] op);
    logic sys_mov;
    sys_mov = ((op[15:12] == 4'h4) && ((op[7:0] == 8'h5a) || (op[7:0] == 8'h56) || (op[7:0] == 8'h6a)
              || (op[7:0] == 8'h66) || (op[7:0] == 8'h52) || (op[7:0] == 8'h62)))
              || ((op[15:12] == 4'h0) && ((op[7:0] == 8'h5a) || (op[7:0] == 8'h6a)));
    return ((op[15:12] == 4'hf) && (op != cei_pkg::OP_UNDEF)) || sys_mov;
  endfunction

  // event code for an external level, 15 maps to the base
  function automatic logic [11:0] level_code(input logic [3:0] lvl);
    logic [11:0] steps;
    steps = {8'h00, 4'hf - lvl};
    return cei_pkg::EVT_LVL_BASE + 12'(steps * cei_pkg::EVT_LVL_STEP);
  endfunction

  // pins pass two flops before use
  cei_sync #(
    .W(5)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({nmi_pin, external_level_inputs}),
    .q({nmi_s, lvl_s})
  );

  // ****************************************
  // event classification
  // ****************************************
  logic user_mode, blocked, fp_off, undef_op, priv_bad, gen_ill, slot_ill, fp_hit;
  logic [3:0] imask, best_lvl;
  logic use_periph, irq_take, nmi_take, int_open;
  cei_pkg::cei_kind_e kind_d;
  logic [31:0] spc_d, target_d;
  logic [11:0] code_d;

  assign user_mode = !status_word_q[cei_pkg::SW_PRIV_BIT];
  assign blocked = status_word_q[cei_pkg::SW_BLOCK_BIT];
  assign fp_off = status_word_q[cei_pkg::SW_FPD_BIT];
  assign imask = status_word_q[cei_pkg::SW_IMASK_LO +: 4];
  assign undef_op = dec.opcode == cei_pkg::OP_UNDEF;
  // RULE2: privileged in user mode
  assign priv_bad = user_mode && dec.priv && !dec.gbr_access;
  // RULE1: general illegal outside slot
  assign gen_ill = dec.valid && !dec.in_slot && (undef_op || priv_bad);
  // RULE3: slot illegal variants
  // RULE4: pc-modifying and pc-relative in slot
  assign slot_ill = dec.valid && dec.in_slot && (undef_op || priv_bad || dec.pc_modify || dec.pc_relative);
  // RULE9: fp class under fp disable
  assign fp_hit = dec.valid && fp_off && is_fp_insn(dec.opcode);

  // RULE19: blocked masks levels
  // RULE23: sleep lets interrupts through the block
  assign int_open = int_boundary && (!blocked || sleeping);
  assign use_periph = periph_req && (periph_level > lvl_s);
  assign best_lvl = use_periph ? periph_level : lvl_s;
  // RULE16: level must beat the mask
  assign irq_take = int_open && (best_lvl > imask);
  // RULE15: nmi beats the mask; blocked case by software bit or sleep
  assign nmi_take = int_boundary && nmi_pend_q && (!blocked || nmi_accept_q || sleeping);

  // pick one event; older pipeline events first
  always_comb begin
    kind_d = cei_pkg::CEI_NONE;
    spc_d = dec.pc;
    code_d = cei_pkg::EVT_NONE;
    target_d = vector_base_q + cei_pkg::VEC_GENERAL;
    if (fpu_exc) begin
      // RULE13: fp operation code
      kind_d = cei_pkg::CEI_FPU_EXC;
      spc_d = fpu_pc;
      code_d = cei_pkg::EVT_FPU_EXC;
    end else if (slot_ill || (fp_hit && dec.in_slot)) begin
      // RULE5: slot save points at the branch
      kind_d = slot_ill ? cei_pkg::CEI_SLOT_ILL : cei_pkg::CEI_SLOT_FPU;
      spc_d = dec.pc - cei_pkg::INSN_BYTES;
      // RULE10: slot fp disable code
      code_d = slot_ill ? cei_pkg::EVT_SLOT_ILL : cei_pkg::EVT_SLOT_FPU;
    end else if (gen_ill || fp_hit) begin
      // RULE6: faulting address saved
      // RULE8: general fp disable code
      kind_d = gen_ill ? cei_pkg::CEI_GEN_ILL : cei_pkg::CEI_FPU_DIS;
      code_d = gen_ill ? cei_pkg::EVT_GEN_ILL : cei_pkg::EVT_FPU_DIS;
    end else if (ubreak) begin
      // RULE11: pre or post break address
      kind_d = cei_pkg::CEI_UBREAK;
      spc_d = ubreak_post ? ubreak_pc + cei_pkg::INSN_BYTES : ubreak_pc;
      code_d = cei_pkg::EVT_UBREAK;
      // RULE12: debug base when enabled
      target_d = brk_debug_en_q ? debug_base_q : vector_base_q + cei_pkg::VEC_GENERAL;
    end else if (nmi_take || irq_take) begin
      // RULE17: return to the next instruction
      kind_d = cei_pkg::CEI_INTR;
      spc_d = int_next_pc;
      target_d = vector_base_q + cei_pkg::VEC_INTERRUPT;
      // RULE14: nmi code
      // RULE20: peripheral code from the controller
      // RULE24: level code table
      code_d = nmi_take ? cei_pkg::EVT_NMI : (use_periph ? periph_code : level_code(lvl_s));
    end
  end

  logic exc_d, bl_fault;
  assign exc_d = (kind_d != cei_pkg::CEI_NONE) && (kind_d != cei_pkg::CEI_INTR);
  // RULE22: exception other than break while blocked
  assign bl_fault = exc_d && blocked && (kind_d != cei_pkg::CEI_UBREAK);

  // ****************************************
  // fetch redirect
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      entry_q <= '0;
      periph_ack_q <= 1'b0;
    end else begin
      entry_q.redirect <= kind_d != cei_pkg::CEI_NONE;
      entry_q.cpu_reset <= bl_fault;
      entry_q.target <= bl_fault ? cei_pkg::RESET_ADDR : target_d;
      periph_ack_q <= (kind_d == cei_pkg::CEI_INTR) && !nmi_take && use_periph;
    end
  end

  // nmi edge capture; a new edge beats the acceptance clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
      if (nmi_s && !nmi_prev_q) begin
        nmi_pend_q <= 1'b1;
      end else if ((kind_d == cei_pkg::CEI_INTR) && nmi_take) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // saved state and event codes
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      saved_pc_q <= '0;
      saved_status_q <= '0;
      exc_code_q <= cei_pkg::EVT_NONE;
      int_code_q <= cei_pkg::EVT_NONE;
    end else if (bl_fault) begin
      exc_code_q <= cei_pkg::EVT_BL_RESET;
    end else if (kind_d != cei_pkg::CEI_NONE) begin
      saved_pc_q <= spc_d;
      saved_status_q <= status_word_q;
      if (kind_d == cei_pkg::CEI_INTR) begin
        int_code_q <= code_d;
      end else begin
        exc_code_q <= code_d;
      end
    end else if (bus_wr && (avs_address == cei_pkg::REG_SAVED_PC)) begin
      saved_pc_q <= avs_writedata;
    end else if (bus_wr && (avs_address == cei_pkg::REG_SAVED_STATUS)) begin
      saved_status_q <= avs_writedata;
    end
  end

  // status word; hardware entry wins over a software write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_word_q <= cei_pkg::SW_RESET;
    end else if (bl_fault) begin
      status_word_q <= cei_pkg::SW_RESET;
    end else if (kind_d != cei_pkg::CEI_NONE) begin
      // RULE7: block, privilege, bank set
      // RULE18: mask field left alone
      status_word_q[cei_pkg::SW_BLOCK_BIT] <= 1'b1;
      status_word_q[cei_pkg::SW_PRIV_BIT] <= 1'b1;
      status_word_q[cei_pkg::SW_BANK_BIT] <= 1'b1;
    end else if (bus_wr && (avs_address == cei_pkg::REG_STATUS)) begin
      status_word_q <= avs_writedata & cei_pkg::SW_WRITE_MASK;
    end
  end

  // ****************************************
  // avalon slave: one wait cycle per access
  // ****************************************
  assign bus_req = (avs_read || avs_write) && avs_waitrequest;
  assign bus_wr = avs_write && !avs_waitrequest;

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vector_base_q <= cei_pkg::BASE_RESET;
      debug_base_q <= cei_pkg::BASE_RESET;
      brk_debug_en_q <= 1'b0;
      nmi_accept_q <= 1'b0;
    end else if (bus_wr) begin
      case (avs_address)
        cei_pkg::REG_VECTOR_BASE: vector_base_q <= avs_writedata;
        cei_pkg::REG_DEBUG_BASE: debug_base_q <= avs_writedata;
        cei_pkg::REG_BREAK_CONTROL: brk_debug_en_q <= avs_writedata[cei_pkg::BRK_DEBUG_EN_BIT];
        cei_pkg::REG_NMI_CONTROL: nmi_accept_q <= avs_writedata[cei_pkg::NMI_ACCEPT_BIT];
        default: ;
      endcase
    end
  end

  // handshake and read mux
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        case (avs_address)
          cei_pkg::REG_STATUS: avs_readdata <= status_word_q;
          cei_pkg::REG_SAVED_PC: avs_readdata <= saved_pc_q;
          cei_pkg::REG_SAVED_STATUS: avs_readdata <= saved_status_q;
          cei_pkg::REG_EXC_CODE: avs_readdata <= {20'h00000, exc_code_q};
          cei_pkg::REG_INT_CODE: avs_readdata <= {20'h00000, int_code_q};
          cei_pkg::REG_VECTOR_BASE: avs_readdata <= vector_base_q;
          cei_pkg::REG_DEBUG_BASE: avs_readdata <= debug_base_q;
          cei_pkg::REG_BREAK_CONTROL: avs_readdata <= {31'h00000000, brk_debug_en_q};
          cei_pkg::REG_NMI_CONTROL: avs_readdata <= {31'h00000000, nmi_accept_q};
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic quiet_older;
  assign quiet_older = !fpu_exc && !blocked;

  a_undef_code: assert property (@(posedge clk_sys) disable iff (srst) // RULE1
    (quiet_older && dec.valid && !dec.in_slot && undef_op) |=> (exc_code_q == 12'h180)
    && entry_q.redirect && (entry_q.target == vector_base_q + 32'h100))
    else $error("undefined code entry wrong");

  a_priv_user: assert property (@(posedge clk_sys) disable iff (srst) // RULE2
    (quiet_older && dec.valid && !dec.in_slot && user_mode && dec.priv && !dec.gbr_access)
    |=> (exc_code_q == 12'h180))
    else $error("user privileged not trapped");

  a_slot_code: assert property (@(posedge clk_sys) disable iff (srst) // RULE4
    (quiet_older && dec.valid && dec.in_slot && dec.pc_modify)
    |=> (exc_code_q == 12'h1a0) && (saved_pc_q == $past(dec.pc) - 32'h2))
    else $error("slot illegal entry wrong");

  a_fpd_code: assert property (@(posedge clk_sys) disable iff (srst) // RULE8
    (quiet_older && dec.valid && !dec.in_slot && fp_off && (dec.opcode[15:12] == 4'hf) && !undef_op
    && !priv_bad) |=> (exc_code_q == 12'h800) && (saved_pc_q == $past(dec.pc)))
    else $error("fp disable entry wrong");

  a_entry_bits: assert property (@(posedge clk_sys) disable iff (srst) // RULE7
    (entry_q.redirect && !entry_q.cpu_reset) |-> (status_word_q[30:28] == 3'b111))
    else $error("entry status bits not set");

  a_break_dest: assert property (@(posedge clk_sys) disable iff (srst) // RULE12
    (ubreak && brk_debug_en_q && !fpu_exc && !dec.valid) |=> (entry_q.target == $past(debug_base_q))
    && (exc_code_q == 12'h1e0))
    else $error("break destination wrong");

  a_irq_blocked: assert property (@(posedge clk_sys) disable iff (srst) // RULE19
    (blocked && !sleeping && !nmi_pend_q) |=> !(entry_q.redirect && (entry_q.target == $past(vector_base_q)
    + 32'h600))) else $error("interrupt taken while blocked");

  a_mask_kept: assert property (@(posedge clk_sys) disable iff (srst) // RULE18
    (kind_d == cei_pkg::CEI_INTR) |=> (status_word_q[7:4] == $past(imask)))
    else $error("mask changed on interrupt");

  a_nmi_entry: assert property (@(posedge clk_sys) disable iff (srst) // RULE14
    (nmi_take && !fpu_exc && !dec.valid && !ubreak) |=> (int_code_q == 12'h1c0)
    && (entry_q.target == $past(vector_base_q) + 32'h600))
    else $error("nmi entry wrong");

  a_bl_reset: assert property (@(posedge clk_sys) disable iff (srst) // RULE22
    (blocked && (fpu_exc || (dec.valid && undef_op))) |=> entry_q.cpu_reset && (entry_q.target == 32'ha0000000)
    && (exc_code_q == 12'h020) && (status_word_q == 32'h700000f0))
    else $error("blocked exception did not reset");

endmodule

// file: tb/cei_intc_model.sv
// interrupt controller model holding a peripheral request until it is acknowledged
`timescale 1ns/1ns
module cei_intc_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic [3:0] level,
  input wire logic [11:0] code,
  input wire logic periph_ack_q,
  output logic periph_req,
  output logic [3:0] periph_level,
  output logic [11:0] periph_code
);
  // request rises on start and drops once the block acknowledges
  always_ff @(posedge clk_sys) begin
    if (srst || periph_ack_q) begin
      periph_req <= 1'b0;
    end else if (start) begin
      periph_req <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      periph_level <= 4'h0;
      periph_code <= 12'h000;
    end else if (start) begin
      periph_level <= level;
      periph_code <= code;
    end else if (!periph_req) begin
      periph_level <= ~periph_level; // idle lines keep moving
      periph_code <= ~periph_code;
    end
  end
endmodule

// file: tb/test_cei_entry.sv
// self-checking bench of the exception and interrupt entry block
`timescale 1ns/1ns
module test_cei_entry;
  localparam logic [31:0] PC = 32'h00001238;
  localparam logic [31:0] VB = 32'h00004000;
  localparam logic [31:0] DB = 32'h00008000;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  cei_pkg::cei_dec_s dec = '0;
  cei_pkg::cei_entry_s entry_q;
  logic fpu_exc = 1'b0, ubreak = 1'b0, ubreak_post = 1'b0, int_boundary = 1'b0, sleeping = 1'b0;
  logic nmi_pin = 1'b0, start = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic periph_ack_q, periph_req, avs_waitrequest;
  logic [31:0] fpu_pc = '0, ubreak_pc = '0, int_next_pc = '0, avs_writedata = '0;
  logic [31:0] avs_readdata, status_word_q, rd;
  logic [3:0] external_level_inputs = '0, avs_address = '0, p_level = '0, periph_level;
  logic [11:0] p_code = '0, periph_code;
  int num_errors = 0;
  int checks = 0;
  // clock at 50 MHz
  always #10 clk_sys = ~clk_sys;
  cei_entry cei_entry_inst (.clk_sys, .srst, .dec, .fpu_exc, .fpu_pc, .ubreak, .ubreak_post, .ubreak_pc,
    .int_boundary, .int_next_pc, .sleeping, .nmi_pin, .external_level_inputs, .periph_req, .periph_level,
    .periph_code, .periph_ack_q, .entry_q, .status_word_q, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  cei_intc_model cei_intc_model_inst (.clk_sys, .srst, .start, .level(p_level), .code(p_code),
    .periph_ack_q, .periph_req, .periph_level, .periph_code);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // bounded wait for a redirect or a cpu reset pulse
  task automatic wait_entry(input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      if (entry_q.redirect === 1'b1 || entry_q.cpu_reset === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask
  task automatic expect_none();
    logic seen;
    wait_entry(8, seen);
    check({31'h0, seen}, 32'h0);
  endtask
  // entry seen, then target, code, saved state and new status compared
  task automatic expect_entry(input logic [31:0] tgt, input logic [3:0] creg, input logic [11:0] code,
    input logic [31:0] saved_pc, input logic [31:0] saved_status);
    logic seen;
    wait_entry(8, seen);
    check({31'h0, seen}, 32'h1);
    check(entry_q.target, tgt);
    bus(1'b0, creg, 0);
    check(rd, {20'h0, code});
    bus(1'b0, cei_pkg::REG_SAVED_PC, 0);
    check(rd, saved_pc);
    bus(1'b0, cei_pkg::REG_SAVED_STATUS, 0);
    check(rd, saved_status);
    bus(1'b0, cei_pkg::REG_STATUS, 0);
    check(rd, saved_status | 32'h70000000);
  endtask
  // one decode event held for a single cycle, then dec cleared
  task automatic decode(input logic [15:0] op, input logic slot, priv, global_base, pcm, pcr);
    @(posedge clk_sys);
    dec <= '{valid: 1'b1, opcode: op, in_slot: slot, pc: PC, priv: priv, gbr_access: global_base,
      pc_modify: pcm, pc_relative: pcr};
    @(posedge clk_sys);
    dec <= '0;
  endtask
  task automatic t_reset();
    bus(1'b0, cei_pkg::REG_STATUS, 0);
    check(rd, 32'h700000f0);
    bus(1'b0, 4'hf, 0);
    check(rd, 32'h0);
    bus(1'b1, cei_pkg::REG_VECTOR_BASE, VB);
  endtask
  task automatic t_illegal();
    logic [15:0] ops [4] = '{16'hfffd, 16'ha000, 16'hc700, 16'h4027};
    bus(1'b1, cei_pkg::REG_STATUS, 0);
    decode(16'hfffd, 0, 0, 0, 0, 0);
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h180, PC, 0);
    bus(1'b1, cei_pkg::REG_STATUS, 0);
    decode(16'h4027, 0, 1, 0, 0, 0);
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h180, PC, 0);
    bus(1'b1, cei_pkg::REG_STATUS, 0);
    decode(16'h401e, 0, 1, 1, 0, 0);
    expect_none();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, cei_pkg::REG_STATUS, 0);
      decode(ops[i], 1, i == 3, 0, i == 1, i == 2);
      expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h1a0, PC - 2, 0);
    end
  endtask
  task automatic t_fpu();
    bus(1'b1, cei_pkg::REG_STATUS, 32'h00008000);
    decode(16'hf00c, 0, 0, 0, 0, 0);
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h800, PC, 32'h8000);
    bus(1'b1, cei_pkg::REG_STATUS, 32'h00008000);
    decode(16'h405a, 0, 0, 0, 0, 0);
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h800, PC, 32'h8000);
    bus(1'b1, cei_pkg::REG_STATUS, 32'h00008000);
    decode(16'hf00c, 1, 0, 0, 0, 0);
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h820, PC - 2, 32'h8000);
    bus(1'b1, cei_pkg::REG_STATUS, 0);
    decode(16'hf00c, 0, 0, 0, 0, 0);
    expect_none();
    @(posedge clk_sys);
    fpu_exc <= 1'b1;
    fpu_pc <= PC + 4;
    @(posedge clk_sys);
    fpu_exc <= 1'b0;
    expect_entry(VB + 32'h100, cei_pkg::REG_EXC_CODE, 12'h120, PC + 4, 0);
  endtask
  task automatic t_break();
    bus(1'b1, cei_pkg::REG_DEBUG_BASE, DB);
    for (int post = 0; post < 2; post++) begin
      bus(1'b1, cei_pkg::REG_BREAK_CONTROL, post == 0);
      bus(1'b1, cei_pkg::REG_STATUS, 0);
      @(posedge clk_sys);
      ubreak <= 1'b1;
      ubreak_post <= post[0];
      ubreak_pc <= PC;
      @(posedge clk_sys);
      ubreak <= 1'b0;
      expect_entry(post ? VB + 32'h100 : DB, cei_pkg::REG_EXC_CODE, 12'h1e0, PC + 2 * post, 0);
    end
  endtask
  task automatic t_levels();
    bus(1'b1, cei_pkg::REG_STATUS, 32'h50);
    external_level_inputs <= 4'h5;
    int_boundary <= 1'b1;
    int_next_pc <= PC + 2;
    expect_none();
    external_level_inputs <= 4'h6;
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h320, PC + 2, 32'h50);
    external_level_inputs <= 4'hf;
    expect_none();
    bus(1'b1, cei_pkg::REG_STATUS, 0);
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h200, PC + 2, 0);
    external_level_inputs <= 4'h0;
  endtask
  task automatic t_nmi_periph();
    bus(1'b1, cei_pkg::REG_STATUS, 32'hf0);
    int_next_pc <= PC + 6;
    nmi_pin <= 1'b1;
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h1c0, PC + 6, 32'hf0);
    nmi_pin <= 1'b0;
    bus(1'b1, cei_pkg::REG_STATUS, 32'h50);
    p_level <= 4'h7;
    p_code <= 12'h400;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h400, PC + 6, 32'h50);
    check({31'h0, periph_req}, 32'h0);
    nmi_pin <= 1'b1;
    expect_none();
    bus(1'b1, cei_pkg::REG_NMI_CONTROL, 1);
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h1c0, PC + 6, 32'h70000050);
    int_boundary <= 1'b0;
    nmi_pin <= 1'b0;
  endtask
  task automatic t_blocked();
    logic seen;
    // sleep lets a level through the block; one boundary only
    bus(1'b1, cei_pkg::REG_STATUS, 32'h10000000);
    external_level_inputs <= 4'h3;
    sleeping <= 1'b1;
    repeat (3) @(posedge clk_sys);
    int_boundary <= 1'b1;
    @(posedge clk_sys);
    int_boundary <= 1'b0;
    expect_entry(VB + 32'h600, cei_pkg::REG_INT_CODE, 12'h380, PC + 6, 32'h10000000);
    sleeping <= 1'b0;
    external_level_inputs <= 4'h0;
    decode(16'hfffd, 0, 0, 0, 0, 0);
    wait_entry(8, seen);
    check({31'h0, entry_q.cpu_reset}, 32'h1);
    check(entry_q.target, 32'ha0000000);
    bus(1'b0, cei_pkg::REG_EXC_CODE, 0);
    check(rd, 32'h20);
    bus(1'b0, cei_pkg::REG_STATUS, 0);
    check(rd, 32'h700000f0);
    check(status_word_q, 32'h700000f0);
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_illegal();
    t_fpu();
    t_break();
    t_levels();
    t_nmi_periph();
    t_blocked();
    tally_and_finish();
  end
endmodule
